// [src/hall_output_conditioning.sv]
// output conditioning of a programmable linear field sensor: settings,
// permanent lock, raw sample readout and the gain/offset/limit datapath
// assumes the supply-modulation telegram is decoded outside into one-cycle
// commands, and the nonvolatile lock cell is reached through nv_lock_*
//
// Function
// (RQ1) The raw sample is multiplied by a signed gain covering -4 to +4 in 1/2048 steps.
// (RQ2) A unity gain moves the output one full supply span per 2048 sample counts.
// (RQ3) The zero-field offset is added so a zero sample yields the offset.
// (RQ4) With a negative offset the output never exceeds offset plus full span; the lower limit, applied after this ceiling, wins when it lies above it.
// (RQ5) The output never falls below the lower output limit.
// (RQ6) The output never rises above the upper output limit; when the limits cross, the lower limit is applied last and wins.
// (RQ7) Once locked every setting is frozen and all commands are ignored; here a reset still returns the settings to their reset values.
// (RQ8) The lock bit never returns to zero through any write or reset; permanent_lock_bit_r clears in reset, reloads from nv_lock_in.
// (RQ9) A locked device answers neither writes nor reads, raw sample included.
// (RQ10) The raw 14-bit sample before any processing is readable.
// (RQ11) Before lock the settings may be rewritten any number of times.
// (RQ12) The programmer reads two calibration samples and writes computed gain and offset.
// (RQ13) The programmer finishes calibration with the lock command.
// (RQ14) Processing runs gain, then offset, then limits, then output.
// (RQ15) Intermediate results saturate at the output range instead of wrapping.
`timescale 1ns/1ps
`default_nettype none
module hall_output_conditioning
   import hall_cond_pkg::*;
(
   input  wire logic                       clk,
   input  wire logic                       resetn,
   input  wire logic                       sample_valid,
   input  wire logic signed [SAMPLE_W-1:0] sample_in,
   input  wire logic                       cmd_valid,
   input  wire logic                       cmd_write,
   input  wire logic [ADDR_W-1:0]          cmd_addr,
   input  wire logic [DATA_W-1:0]          cmd_wdata,
   input  wire logic                       nv_lock_in,
   output var  logic                       rsp_valid_r,
   output var  logic [DATA_W-1:0]          rsp_data_r,
   output var  logic                       nv_lock_prog_r,
   output var  logic                       locked_r,
   output var  logic [OUT_W-1:0]           out_code_r,
   output var  logic                       out_valid_r
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   logic signed [GAIN_W-1:0]   gain_factor_r;
   logic signed [OFFS_W-1:0]   zero_field_offset_r;
   logic [LOW_W-1:0]           lower_output_limit_r;
   logic [HIGH_W-1:0]          upper_output_limit_r;
   logic                       permanent_lock_bit_r;
   logic signed [SAMPLE_W-1:0] raw_field_sample_r;
   logic                       boot_done_r;
   logic                       cmd_ok;
   logic                       wr_ok;
   logic                       lock_set;
   logic signed [SCALE_W-1:0]  scaled_r;
   logic                       scaled_vld_r;
   logic [OUT_W-1:0]           out_code;
   logic [DATA_W-1:0]          rd_data;

   // commands count only after the stored lock state has been loaded
   assign cmd_ok   = cmd_valid && boot_done_r && !permanent_lock_bit_r; // RQ7 RQ9
   assign wr_ok    = cmd_ok && cmd_write;
   assign lock_set = wr_ok && cmd_addr == IDX_LOCK && cmd_wdata[0];

   function automatic logic hits(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] idx);
      hits = (a == idx);
   endfunction

   // ----------------------------------------------------------------
   // lock and boot
   // ----------------------------------------------------------------
   // the flop clears on reset but is reloaded from the nonvolatile cell on
   // the first edge after release; commands are held off until then
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         boot_done_r <= 1'b0;
      end else begin
         boot_done_r <= 1'b1;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         permanent_lock_bit_r <= 1'b0;
      end else if (!boot_done_r) begin
         permanent_lock_bit_r <= nv_lock_in; // RQ8
      end else if (lock_set) begin
         permanent_lock_bit_r <= 1'b1; // RQ8
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         nv_lock_prog_r <= 1'b0;
         locked_r       <= 1'b0;
      end else begin
         nv_lock_prog_r <= lock_set;
         locked_r       <= permanent_lock_bit_r || lock_set;
      end
   end

   // ----------------------------------------------------------------
   // settings
   // ----------------------------------------------------------------
   // no write counter: rewrites are unlimited until lock
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         gain_factor_r        <= GAIN_RST;
         zero_field_offset_r  <= OFFSET_RST;
         lower_output_limit_r <= LOW_RST;
         upper_output_limit_r <= HIGH_RST;
      end else if (wr_ok) begin // RQ11
         if (hits(cmd_addr, IDX_GAIN)) begin
            gain_factor_r <= $signed(cmd_wdata[GAIN_W-1:0]);
         end
         if (hits(cmd_addr, IDX_OFFSET)) begin
            zero_field_offset_r <= $signed(cmd_wdata[OFFS_W-1:0]);
         end
         if (hits(cmd_addr, IDX_LOW)) begin
            lower_output_limit_r <= cmd_wdata[LOW_W-1:0];
         end
         if (hits(cmd_addr, IDX_HIGH)) begin
            upper_output_limit_r <= cmd_wdata[HIGH_W-1:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // raw sample
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         raw_field_sample_r <= '0;
      end else if (sample_valid) begin
         raw_field_sample_r <= sample_in; // RQ10
      end
   end

   // ----------------------------------------------------------------
   // answers
   // ----------------------------------------------------------------
   always_comb begin
      rd_data = '0;
      unique case (cmd_addr)
         IDX_GAIN:   rd_data = DATA_W'(unsigned'(gain_factor_r));
         IDX_OFFSET: rd_data = {{(DATA_W-OFFS_W){1'b0}}, zero_field_offset_r};
         IDX_LOW:    rd_data = {{(DATA_W-LOW_W){1'b0}}, lower_output_limit_r};
         IDX_HIGH:   rd_data = {{(DATA_W-HIGH_W){1'b0}}, upper_output_limit_r};
         IDX_LOCK:   rd_data = {{(DATA_W-1){1'b0}}, permanent_lock_bit_r};
         IDX_SAMPLE: rd_data = DATA_W'(unsigned'(raw_field_sample_r)); // RQ10
         default:    rd_data = '0;
      endcase
   end

   // every accepted command is answered once; writes echo zero data
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rsp_valid_r <= 1'b0;
         rsp_data_r  <= '0;
      end else begin
         rsp_valid_r <= cmd_ok; // RQ9
         if (cmd_ok) begin
            rsp_data_r <= cmd_write ? '0 : rd_data;
         end
      end
   end

   // ----------------------------------------------------------------
   // datapath
   // ----------------------------------------------------------------
   hall_gain_mult u_mult (
      .clk          (clk),
      .resetn       (resetn),
      .sample_valid (sample_valid),
      .sample       (sample_in),
      .gain         (gain_factor_r),
      .scaled_r     (scaled_r),
      .scaled_vld_r (scaled_vld_r)
   );

   hall_out_limit u_limit (
      .scaled   (scaled_r),
      .offset   (zero_field_offset_r),
      .low_lim  (lower_output_limit_r),
      .high_lim (upper_output_limit_r),
      .out_code (out_code)
   );

   // output keeps its last value between samples
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         out_code_r  <= '0;
         out_valid_r <= 1'b0;
      end else begin
         out_valid_r <= scaled_vld_r; // RQ14
         if (scaled_vld_r) begin
            out_code_r <= out_code;
         end
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   chk_lock_stays_set : assert property ( // RQ8
      @(posedge clk) disable iff (!resetn)
      permanent_lock_bit_r |=> permanent_lock_bit_r [*3])
      else $error("lock bit returned to zero");

   chk_locked_freeze : assert property ( // RQ7
      @(posedge clk) disable iff (!resetn)
      permanent_lock_bit_r |=> $stable(gain_factor_r) && $stable(zero_field_offset_r)
         && $stable(lower_output_limit_r) && $stable(upper_output_limit_r))
      else $error("setting changed while locked");

   chk_locked_silent : assert property ( // RQ9
      @(posedge clk) disable iff (!resetn)
      permanent_lock_bit_r && cmd_valid |=> !rsp_valid_r)
      else $error("locked device answered a command");

   chk_read_answer : assert property ( // RQ10
      @(posedge clk) disable iff (!resetn)
      cmd_ok && !cmd_write && cmd_addr == IDX_SAMPLE
      |=> rsp_valid_r && rsp_data_r == DATA_W'(unsigned'($past(raw_field_sample_r))))
      else $error("raw sample read returned wrong data");

   chk_gain_rewrite : assert property ( // RQ11
      @(posedge clk) disable iff (!resetn)
      wr_ok && cmd_addr == IDX_GAIN
      |=> gain_factor_r == $signed($past(cmd_wdata)))
      else $error("unlocked gain write not taken");

   chk_sample_latency : assert property ( // RQ14
      @(posedge clk) disable iff (!resetn)
      sample_valid |-> ##2 out_valid_r)
      else $error("output not produced two cycles after sample");

   chk_lower_limit : assert property ( // RQ5
      @(posedge clk) disable iff (!resetn)
      out_valid_r |-> out_code_r >= OUT_W'({$past(lower_output_limit_r), 1'b0}))
      else $error("output below lower limit");

   chk_upper_limit : assert property ( // RQ6
      @(posedge clk) disable iff (!resetn)
      out_valid_r && $past(lower_output_limit_r) <= $past(upper_output_limit_r)
      |-> out_code_r <= OUT_W'({$past(upper_output_limit_r), 1'b0}))
      else $error("output above upper limit");

   chk_neg_offset_ceiling : assert property ( // RQ4
      @(posedge clk) disable iff (!resetn)
      out_valid_r && $past(zero_field_offset_r) < 0 && $past(lower_output_limit_r) == 0
      |-> $signed({8'h00, out_code_r}) <=
          (SUM_W'($past(zero_field_offset_r)) <<< OFFS_SHIFT) + FULL_SPAN)
      else $error("output above negative offset ceiling");

   chk_zero_sample_offset : assert property ( // RQ3
      @(posedge clk) disable iff (!resetn)
      sample_valid && sample_in == 0 && zero_field_offset_r >= 0
         && lower_output_limit_r == 0 && upper_output_limit_r == HIGH_RST
         ##1 ($stable(zero_field_offset_r) && $stable(lower_output_limit_r)
         && $stable(upper_output_limit_r))
      |=> out_code_r == OUT_W'(unsigned'($past(zero_field_offset_r)) << OFFS_SHIFT))
      else $error("zero sample did not give the offset");

   chk_lock_program : assert property ( // RQ8
      @(posedge clk) disable iff (!resetn)
      lock_set |=> nv_lock_prog_r && permanent_lock_bit_r && locked_r)
      else $error("lock command did not set and program the lock");

   chk_boot_reload : assert property ( // RQ8
      @(posedge clk) disable iff (!resetn)
      $rose(boot_done_r) |-> permanent_lock_bit_r == $past(nv_lock_in))
      else $error("lock bit not reloaded from the cell");

   chk_locked_level : assert property ( // RQ7
      @(posedge clk) disable iff (!resetn)
      permanent_lock_bit_r |=> locked_r)
      else $error("locked output does not follow the lock bit");

   chk_write_answer : assert property ( // RQ11
      @(posedge clk) disable iff (!resetn)
      wr_ok |=> rsp_valid_r && rsp_data_r == '0)
      else $error("accepted write not answered with zero");

   chk_raw_capture : assert property ( // RQ10
      @(posedge clk) disable iff (!resetn)
      sample_valid |=> raw_field_sample_r == $past(sample_in))
      else $error("raw sample not captured");

   chk_output_hold : assert property ( // RQ14
      @(posedge clk) disable iff (!resetn)
      !out_valid_r |-> $stable(out_code_r))
      else $error("output code changed without a result");

   cov_lock_set    : cover property (@(posedge clk) disable iff (!resetn) lock_set);
   cov_sample_read : cover property (@(posedge clk) disable iff (!resetn)
      cmd_ok && !cmd_write && cmd_addr == IDX_SAMPLE);
   cov_upper_clamp : cover property (@(posedge clk) disable iff (!resetn)
      out_valid_r && out_code_r == OUT_W'({upper_output_limit_r, 1'b0}));
   cov_locked_cmd  : cover property (@(posedge clk) disable iff (!resetn)
      permanent_lock_bit_r && cmd_valid);
   cov_neg_offset  : cover property (@(posedge clk) disable iff (!resetn)
      out_valid_r && zero_field_offset_r < 0);

endmodule // hall_output_conditioning
`default_nettype wire

// [src/hall_cond_pkg.sv]
// constants shared by the output conditioning datapath and its register file
// assumes one 10 MHz clock and a decoded command port in front of it
package hall_cond_pkg;

   // ----------------------------------------------------------------
   // widths
   // ----------------------------------------------------------------
   localparam int SAMPLE_W = 14;
   localparam int GAIN_W   = 14;
   localparam int OFFS_W   = 11;
   localparam int LOW_W    = 10;
   localparam int HIGH_W   = 11;
   localparam int OUT_W    = 12;
   localparam int PROD_W   = SAMPLE_W + GAIN_W;
   localparam int SCALE_W  = PROD_W - 10;
   localparam int SUM_W    = 20;
   localparam int ADDR_W   = 3;
   localparam int DATA_W   = 14;

   // ----------------------------------------------------------------
   // scaling: output code lsb is one 4096th of the supply
   // ----------------------------------------------------------------
   localparam int PROD_SHIFT = 10;
   localparam int OFFS_SHIFT = 2;
   localparam int CLMP_SHIFT = 1;
   localparam logic signed [SUM_W-1:0] FULL_SPAN = 20'sh01000;
   localparam logic signed [SUM_W-1:0] OUT_MAX   = 20'sh00fff;
   localparam logic signed [SUM_W-1:0] OUT_MIN   = 20'sh00000;
   localparam logic signed [GAIN_W-1:0] GAIN_UNITY = 14'sh0800;

   // ----------------------------------------------------------------
   // register indexes on the command port
   // ----------------------------------------------------------------
   localparam logic [ADDR_W-1:0] IDX_GAIN   = 3'h0;
   localparam logic [ADDR_W-1:0] IDX_OFFSET = 3'h1;
   localparam logic [ADDR_W-1:0] IDX_LOW    = 3'h2;
   localparam logic [ADDR_W-1:0] IDX_HIGH   = 3'h3;
   localparam logic [ADDR_W-1:0] IDX_LOCK   = 3'h4;
   localparam logic [ADDR_W-1:0] IDX_SAMPLE = 3'h5;

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic signed [GAIN_W-1:0] GAIN_RST   = 14'sh0800;
   localparam logic signed [OFFS_W-1:0] OFFSET_RST = 11'sh200;
   localparam logic [LOW_W-1:0]         LOW_RST    = 10'h000;
   localparam logic [HIGH_W-1:0]        HIGH_RST   = 11'h7ff;

endpackage : hall_cond_pkg

// [src/hall_gain_mult.sv]
// registered multiply of the raw sample by the gain factor
// assumes sample and gain are stable in the cycle sample_valid is high
`timescale 1ns/1ps
`default_nettype none
module hall_gain_mult
   import hall_cond_pkg::*;
(
   input  wire logic                       clk,
   input  wire logic                       resetn,
   input  wire logic                       sample_valid,
   input  wire logic signed [SAMPLE_W-1:0] sample,
   input  wire logic signed [GAIN_W-1:0]   gain,
   output var  logic signed [SCALE_W-1:0]  scaled_r,
   output var  logic                       scaled_vld_r
);

   // ----------------------------------------------------------------
   // multiplier
   // ----------------------------------------------------------------
   // gain lsb is 1/2048 of unity, so product >>> 10 gives 4096 codes per 2048 counts
   logic signed [PROD_W-1:0] prod;
   assign prod = sample * gain; // RQ1

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         scaled_r     <= '0;
         scaled_vld_r <= 1'b0;
      end else begin
         scaled_vld_r <= sample_valid;
         if (sample_valid) begin
            scaled_r <= SCALE_W'(prod >>> PROD_SHIFT); // RQ2
         end
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   chk_unity_gain_scale : assert property ( // RQ2
      @(posedge clk) disable iff (!resetn)
      sample_valid && gain == GAIN_UNITY
      |=> scaled_r == SCALE_W'($signed($past(sample)) * 2))
      else $error("unity gain does not double the sample");

endmodule // hall_gain_mult
`default_nettype wire

// [src/hall_out_limit.sv]
// combinational offset add, negative offset ceiling, clamps and saturation
// assumes the caller registers the result
`timescale 1ns/1ps
`default_nettype none
module hall_out_limit
   import hall_cond_pkg::*;
(
   input  wire logic signed [SCALE_W-1:0] scaled,
   input  wire logic signed [OFFS_W-1:0]  offset,
   input  wire logic [LOW_W-1:0]          low_lim,
   input  wire logic [HIGH_W-1:0]         high_lim,
   output var  logic [OUT_W-1:0]          out_code
);

   // ----------------------------------------------------------------
   // add, limit, saturate
   // ----------------------------------------------------------------
   logic signed [SUM_W-1:0] offs_c;
   logic signed [SUM_W-1:0] sum;
   logic signed [SUM_W-1:0] ceil_c;
   logic signed [SUM_W-1:0] low_c;
   logic signed [SUM_W-1:0] high_c;
   logic signed [SUM_W-1:0] lim;

   always_comb begin
      offs_c = SUM_W'(offset) <<< OFFS_SHIFT;
      sum    = SUM_W'(scaled) + offs_c; // RQ3 RQ14
      low_c  = $signed({{(SUM_W-LOW_W){1'b0}}, low_lim}) <<< CLMP_SHIFT;
      high_c = $signed({{(SUM_W-HIGH_W){1'b0}}, high_lim}) <<< CLMP_SHIFT;
      ceil_c = (offset < 0) ? (offs_c + FULL_SPAN) : OUT_MAX; // RQ4
      lim    = sum;
      if (lim > ceil_c) begin
         lim = ceil_c; // RQ4
      end
      if (lim > high_c) begin
         lim = high_c; // RQ6
      end
      // lower limit applied last so it wins when limits cross
      if (lim < low_c) begin
         lim = low_c; // RQ5
      end
      if (lim > OUT_MAX) begin
         lim = OUT_MAX; // RQ15
      end else if (lim < OUT_MIN) begin
         lim = OUT_MIN; // RQ15
      end
      out_code = lim[OUT_W-1:0];
   end

endmodule // hall_out_limit
`default_nettype wire

// [dv/supply_programmer.sv]
// programmer model: issues decoded supply-modulation commands
// assumes callers enter its tasks just after a rising edge of clk
`timescale 1ns/1ps
`default_nettype none
module supply_programmer
   import hall_cond_pkg::*;
(
   input  wire logic              clk,
   output var  logic              cmd_valid,
   output var  logic              cmd_write,
   output var  logic [ADDR_W-1:0] cmd_addr,
   output var  logic [DATA_W-1:0] cmd_wdata
);
   // ----------------------------------------------------------------
   // command tasks
   // ----------------------------------------------------------------
   initial begin
      cmd_valid = 1'b0;
      cmd_write = 1'b0;
      cmd_addr  = 3'h0;
      cmd_wdata = 14'h0000;
   end

   // strobe stays up so back to back calls issue one command per cycle
   task automatic send(input logic wr, input logic [ADDR_W-1:0] a,
                       input logic [DATA_W-1:0] d);
      cmd_valid <= 1'b1;
      cmd_write <= wr;
      cmd_addr  <= a;
      cmd_wdata <= d;
      @(posedge clk);
   endtask

   // released data shows inverted bits so a stale value never matches
   task automatic idle();
      cmd_valid <= 1'b0;
      cmd_wdata <= ~cmd_wdata;
      @(posedge clk);
   endtask

   task automatic lock();
      send(1'b1, IDX_LOCK, 14'h0001);
      idle();
   endtask
endmodule // supply_programmer
`default_nettype wire

// [dv/hall_output_conditioning_tb_top.sv]
// self-checking bench for the output conditioning block
// assumes supply_programmer drives the command port and a bench cell holds the lock
`timescale 1ns/1ps
`default_nettype none
module hall_output_conditioning_tb_top
   import hall_cond_pkg::*;
();
   logic                       clk          = 1'b0;
   logic                       resetn       = 1'b0;
   logic                       sample_valid = 1'b0;
   logic signed [SAMPLE_W-1:0] sample_in    = 14'sh0000;
   logic                       nv_cell      = 1'b0;
   logic                       cmd_valid, cmd_write, rsp_valid_r, nv_lock_prog_r;
   logic [ADDR_W-1:0]          cmd_addr;
   logic [DATA_W-1:0]          cmd_wdata, rsp_data_r;
   logic                       locked_r, out_valid_r;
   logic [OUT_W-1:0]           out_code_r;
   logic [15:0]                lfsr = 16'h0007;
   logic [15:0]                r;
   logic [DATA_W-1:0]          rsp_q[$];
   logic [DATA_W-1:0]          out_q[$];
   int err_count = 0, comparisons = 0, prog_pulses = 0;
   int g = 2048, off = 512, lo = 0, hi = 2047, cg, co;
   // gain, offset, low, high, sample
   int tbl [8][5] = '{'{2048, 0, 0, 2047, 1024}, '{2048, 300, 0, 2047, 0},
      '{8191, -256, 0, 2047, 2047}, '{2048, 512, 256, 2047, -2000},
      '{2048, 512, 0, 1024, 1500}, '{-2048, 512, 0, 2047, 1000},
      '{1024, -100, 100, 2047, 500}, '{-8192, -1024, 0, 2047, 8191}};

   always #50 clk = ~clk;

   supply_programmer prog (.clk(clk), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
                           .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata));

   hall_output_conditioning DUT (
      .clk            (clk),
      .resetn         (resetn),
      .sample_valid   (sample_valid),
      .sample_in      (sample_in),
      .cmd_valid      (cmd_valid),
      .cmd_write      (cmd_write),
      .cmd_addr       (cmd_addr),
      .cmd_wdata      (cmd_wdata),
      .nv_lock_in     (nv_cell),
      .rsp_valid_r    (rsp_valid_r),
      .rsp_data_r     (rsp_data_r),
      .nv_lock_prog_r (nv_lock_prog_r),
      .locked_r       (locked_r),
      .out_code_r     (out_code_r),
      .out_valid_r    (out_valid_r)
   );

   // nonvolatile cell: only the program pulse ever sets it
   always @(posedge clk) begin
      if (nv_lock_prog_r === 1'b1) begin
         nv_cell <= 1'b1;
         prog_pulses++;
      end
   end

   // ----------------------------------------------------------------
   // checking
   // ----------------------------------------------------------------
   task automatic check(input logic [DATA_W-1:0] got, exp, input string what);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("Error %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   function automatic logic [DATA_W-1:0] model(input int s);
      longint v;
      v = ((longint'(s) * g) >>> 10) + off * 4;
      if (off < 0 && v > off * 4 + 4096) v = off * 4 + 4096;
      if (v > hi * 2) v = hi * 2;
      if (v < lo * 2) v = lo * 2;
      if (v > 4095) v = 4095;
      if (v < 0) v = 0;
      return v[DATA_W-1:0];
   endfunction

   // results stand one cycle; the falling edge sees them settled
   always @(negedge clk) begin
      if (rsp_valid_r === 1'b1) begin
         if (rsp_q.size() == 0) begin
            err_count++;
            $display("Error %0t: answer without an accepted command", $time);
         end else check(rsp_data_r, rsp_q.pop_front(), "answer");
      end
      if (out_valid_r === 1'b1) begin
         if (out_q.size() == 0) begin
            err_count++;
            $display("Error %0t: output without a sample", $time);
         end else check({2'b00, out_code_r}, out_q.pop_front(), "output code");
      end
   end

   task automatic conclude();
      $display("comparisons %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge clk);
      err_count++;
      $display("Error %0t: run did not finish", $time);
      conclude();
   end

   // ----------------------------------------------------------------
   // stimulus
   // ----------------------------------------------------------------
   function automatic logic [15:0] rnd();
      lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      return lfsr;
   endfunction

   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      rsp_q.push_back(14'h0000);
      prog.send(1'b1, a, d);
   endtask

   task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
      rsp_q.push_back(e);
      prog.send(1'b0, a, 14'h0000);
   endtask

   task automatic setup(input int ng, no, nl, nh);
      g = ng;
      off = no;
      lo = nl;
      hi = nh;
      wr(IDX_GAIN, 14'(ng));
      wr(IDX_OFFSET, 14'(no));
      wr(IDX_LOW, 14'(nl));
      wr(IDX_HIGH, 14'(nh));
      prog.idle();
   endtask

   task automatic smp(input int s);
      out_q.push_back(model(s));
      sample_valid <= 1'b1;
      sample_in    <= 14'(s);
      @(posedge clk);
      sample_valid <= 1'b0;
      repeat (3) @(posedge clk);
   endtask

   task automatic drain(input string name);
      int n;
      n = 0;
      while (rsp_q.size() + out_q.size() != 0 && n < 20) begin
         @(posedge clk);
         n++;
      end
      if (rsp_q.size() + out_q.size() != 0) begin
         err_count++;
         $display("Error %0t: results missing in %s", $time, name);
         conclude();
      end else begin
         $display("test %s done", name);
      end
   endtask

   initial begin
      repeat (6) @(posedge clk);
      resetn <= 1'b1;
      repeat (2) @(posedge clk);
      rd(IDX_GAIN, 14'h0800);
      rd(IDX_OFFSET, 14'h0200);
      rd(IDX_LOW, 14'h0000);
      rd(IDX_HIGH, 14'h07ff);
      rd(3'h6, 14'h0000);
      wr(3'h7, 14'h1555);
      rd(3'h7, 14'h0000);
      prog.idle();
      smp(-100);
      wr(IDX_SAMPLE, 14'h0abc);
      rd(IDX_SAMPLE, 14'(-100));
      for (int i = 0; i < 8; i++) begin
         r = rnd();
         wr(IDX_GAIN, r[13:0]);
         rd(IDX_GAIN, r[13:0]);
      end
      prog.idle();
      drain("registers");
      foreach (tbl[i]) begin
         setup(tbl[i][0], tbl[i][1], tbl[i][2], tbl[i][3]);
         smp(tbl[i][4]);
      end
      setup(1500, 100, 50, 1900);
      repeat (16) begin
         r = rnd();
         smp($signed(r[13:0]));
      end
      drain("datapath");
      // two-point calibration toward 4.5 V and 0.5 V
      setup(2048, 512, 0, 2047);
      smp(-2500);
      rd(IDX_SAMPLE, 14'(-2500));
      prog.idle();
      smp(2350);
      rd(IDX_SAMPLE, 14'(2350));
      prog.idle();
      cg = (3686 - 410) * 1024 / (-2500 - 2350);
      co = (3686 - ((-2500 * cg) >>> 10)) / 4;
      setup(cg, co, 205, 1843);
      smp(-2500);
      smp(2350);
      wr(IDX_LOCK, 14'h0000);
      rd(IDX_LOCK, 14'h0000);
      rd(IDX_GAIN, 14'(cg));
      prog.idle();
      drain("calibration");
      rsp_q.push_back(14'h0000);
      prog.lock();
      @(posedge clk);
      check({13'h0000, locked_r}, 14'h0001, "locked state");
      prog.send(1'b1, IDX_GAIN, 14'h0100);
      prog.send(1'b0, IDX_SAMPLE, 14'h0000);
      prog.idle();
      smp(1000);
      drain("lock");
      resetn <= 1'b0;
      repeat (3) @(posedge clk);
      resetn <= 1'b1;
      repeat (3) @(posedge clk);
      check({13'h0000, locked_r}, 14'h0001, "lock after reset");
      prog.send(1'b0, IDX_GAIN, 14'h0000);
      prog.idle();
      repeat (4) @(posedge clk);
      check(14'(prog_pulses), 14'h0001, "lock programming pulses");
      drain("reset while locked");
      conclude();
   end
endmodule // hall_output_conditioning_tb_top
`default_nettype wire
